// [ssr_pkg.sv]
// Package: constants for the status register sets block
package ssr_pkg;

    // Register width and the bits that carry data
    localparam int SSR_W = 16;
    localparam int SSR_DATA_W = 15;
    localparam logic [15:0] SSR_DATA_MASK = 16'h7FFF;

    // Number of sets and set indices
    localparam int SSR_NSETS = 11;
    localparam logic [3:0] SSR_SET_DEV = 4'h0;
    localparam logic [3:0] SSR_SET_OPER = 4'h1;
    localparam logic [3:0] SSR_SET_OPER_CAL = 4'h2;
    localparam logic [3:0] SSR_SET_OPER_LLF = 4'h3;
    localparam logic [3:0] SSR_SET_OPER_MEAS = 4'h4;
    localparam logic [3:0] SSR_SET_OPER_SENSE = 4'h5;
    localparam logic [3:0] SSR_SET_OPER_TRIG = 4'h6;
    localparam logic [3:0] SSR_SET_OPER_ULF = 4'h7;
    localparam logic [3:0] SSR_SET_QUES = 4'h8;
    localparam logic [3:0] SSR_SET_QUES_CAL = 4'h9;
    localparam logic [3:0] SSR_SET_QUES_POW = 4'hA;

    // Summary bit positions in the parent condition registers
    localparam int SSR_OPER_CAL_BIT = 0;
    localparam int SSR_OPER_MEAS_BIT = 4;
    localparam int SSR_OPER_TRIG_BIT = 5;
    localparam int SSR_OPER_SENSE_BIT = 10;
    localparam int SSR_OPER_LLF_BIT = 11;
    localparam int SSR_OPER_ULF_BIT = 12;
    localparam int SSR_QUES_POW_BIT = 3;
    localparam int SSR_QUES_CAL_BIT = 8;
    localparam int SSR_CHILD_BIT = 1;

    // Preset values
    localparam logic [15:0] SSR_PTR_PRESET = 16'h7FFF;
    localparam logic [15:0] SSR_NTR_PRESET = 16'h0000;
    localparam logic [15:0] SSR_ENA_PRESET_TOP = 16'h0000;
    localparam logic [15:0] SSR_ENA_PRESET_OTHER = 16'h7FFF;
    localparam logic SSR_QENA_PRESET = 1'b1;

    // Register selectors within a set
    typedef enum logic [2:0] {
        SSR_REG_COND,
        SSR_REG_EVENT,
        SSR_REG_ENABLE,
        SSR_REG_FALL,
        SSR_REG_RISE
    } ssr_reg_t;

endpackage

// [ssr_set.sv]
// One status register set: condition, event, enable and two filters
`timescale 1ns/100ps
module ssr_set
    import ssr_pkg::*;
#(
    parameter logic [15:0] ENA_PRESET = 16'h7FFF
) (
    input wire logic mclk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic [15:0] cond_in, // Live condition bits
    input wire logic wr_en, // Write strobe for this set
    input wire ssr_reg_t wr_sel, // Register written
    input wire logic [15:0] wr_data, // Rounded write value
    input wire logic evt_rd, // Event read, clears the event bits
    input wire logic clr_evt, // Clear-status command pulse
    input wire logic preset, // Status-preset command pulse
    output logic [15:0] cond_q, // Stored condition
    output logic [15:0] evt_q, // Latched events
    output logic [15:0] ena_q, // Enable mask
    output logic [15:0] fall_q, // Falling filter
    output logic [15:0] rise_q, // Rising filter
    output logic summary // OR of enabled events
);

    logic [15:0] cond_r; // Condition copy, bit 15 held low
    logic [15:0] evt_r; // Event latch
    logic [15:0] ena_r; // Enable mask
    logic [15:0] fall_r; // Falling filter
    logic [15:0] rise_r; // Rising filter
    logic [15:0] hits; // Transitions passing the filters
    logic [15:0] cond_nxt; // New condition

    // Condition bits are only sampled, never changed by reads
    assign cond_nxt = cond_in & SSR_DATA_MASK;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cond_r <= 16'h0000;
        end else begin
            cond_r <= cond_nxt; // R01
        end
    end

    // Edge detection through the filters
    assign hits = ((~cond_r & cond_nxt & rise_r) |
                   (cond_r & ~cond_nxt & fall_r)); // R16

    // Event latch: new events win over a clearing read
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            evt_r <= 16'h0000;
        end else if (clr_evt) begin
            evt_r <= hits; // R11
        end else if (evt_rd) begin
            evt_r <= hits; // R02
        end else begin
            evt_r <= evt_r | hits; // R16
        end
    end

    // Enable mask: power-on reset and preset load it, clear leaves it alone
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ena_r <= ENA_PRESET & SSR_DATA_MASK;
        end else if (preset) begin
            ena_r <= ENA_PRESET & SSR_DATA_MASK; // R09
        end else if (wr_en && wr_sel == SSR_REG_ENABLE) begin
            ena_r <= wr_data & SSR_DATA_MASK; // R03
        end
    end

    // Transition filters
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fall_r <= SSR_NTR_PRESET;
            rise_r <= SSR_PTR_PRESET;
        end else if (preset) begin
            fall_r <= SSR_NTR_PRESET; // R09
            rise_r <= SSR_PTR_PRESET;
        end else if (wr_en && wr_sel == SSR_REG_FALL) begin
            fall_r <= wr_data & SSR_DATA_MASK; // R05
        end else if (wr_en && wr_sel == SSR_REG_RISE) begin
            rise_r <= wr_data & SSR_DATA_MASK; // R07
        end
    end

    assign summary = |(evt_r & ena_r); // R17
    assign cond_q = cond_r;
    assign evt_q = evt_r;
    assign ena_q = ena_r;
    assign fall_q = fall_r;
    assign rise_q = rise_r;

    // Event clears on read unless a fresh edge arrives
    AST_EVT_RD_CLR: assert property (@(posedge mclk) disable iff (rst) // R02
        evt_rd && !clr_evt |=> evt_r == $past(hits))
        else $error("event not cleared by read");
    // Bit 15 of the mask and of both filters never sets
    AST_MASK_TOP: assert property (@(posedge mclk) disable iff (rst) // R03
        !ena_r[15] && !fall_r[15] && !rise_r[15])
        else $error("bit 15 set in mask or filter");

endmodule // ssr_set

// [ssr_top.sv]
// Status register sets: eleven sets, summaries and the 488.2 registers
//
// Overview of operation
// [R01] Condition read returns bits, no change
// [R02] Event read returns bits, then clears
// [R03] Enable write keeps low 15 bits
// [R04] Enable read returns 15-bit value
// [R05] Falling filter write keeps low 15 bits
// [R06] Falling filter read returns 15 bits
// [R07] Rising filter write keeps low 15 bits
// [R08] Rising filter read returns 15 bits
// [R09] Filters and masks preset at power-on/preset
// [R10] Queue enable preset at power-on/preset
// [R11] Clear-status and power-on empty events, queue
// [R12] ESE and SRE cleared at power-on only
// [R13] ESR and STB cleared by clear-status, power-on
// [R14] Five accesses for all eleven sets
// [R15] Host names the set; only it responds
// [R16] Filtered edges latch event bits
// [R17] Enabled events summarise into parent condition
`timescale 1ns/100ps
module ssr_top
    import ssr_pkg::*;
(
    input wire logic mclk, // System clock, 250 MHz
    input wire logic rst, // Power-on reset, async, active high
    input wire logic cmd_rst, // Device reset command pulse
    input wire logic cmd_cls, // Clear-status command pulse
    input wire logic cmd_preset, // Status-preset command pulse
    input wire logic acc_req, // Register access pulse
    input wire logic acc_wr, // 1 write, 0 query
    input wire logic [3:0] acc_set, // Target set index
    input wire ssr_reg_t acc_reg, // Target register
    input wire logic [15:0] acc_wdata, // Write value, already rounded
    output logic [15:0] acc_rdata, // Query answer
    output logic acc_rvalid, // Answer valid pulse
    input wire logic [15:0] dev_cond, // Device set condition bits
    input wire logic [15:0] oper_cond, // Operation own condition bits
    input wire logic [5:0] oper_sub_cond, // Bit 1 of the six summaries
    input wire logic [15:0] ques_cond, // Questionable own condition bits
    input wire logic [1:0] ques_sub_cond, // Bit 1 of the two summaries
    input wire logic queue_push, // Error queue gets an entry
    input wire logic [7:0] esr_set, // Standard event bits to set
    input wire logic ese_wr, // Write event status enable
    input wire logic sre_wr, // Write service request enable
    input wire logic [7:0] ieee_wdata, // Data for the two writes
    output logic [7:0] ese_q, // Event status enable
    output logic [7:0] sre_q, // Service request enable
    output logic [7:0] esr_q, // Standard event status
    output logic [7:0] stb_q, // Status byte
    output logic queue_ena_q, // Error queue enable
    output logic queue_nempty_q, // Error queue holds entries
    output logic dev_sum, // Device set summary
    output logic oper_sum, // Operation summary
    output logic ques_sum // Questionable summary
);

    logic [15:0] cond_in [SSR_NSETS]; // Condition inputs per set
    logic [15:0] cond_q [SSR_NSETS]; // Stored conditions
    logic [15:0] evt_q [SSR_NSETS]; // Event registers
    logic [15:0] ena_q [SSR_NSETS]; // Enable masks
    logic [15:0] fall_q [SSR_NSETS]; // Falling filters
    logic [15:0] rise_q [SSR_NSETS]; // Rising filters
    logic [SSR_NSETS-1:0] sum; // Per-set summaries
    logic [SSR_NSETS-1:0] sel; // One-hot set decode
    logic clr_all; // Clear-status pulse
    logic [7:0] esr_r; // Standard event status
    logic [7:0] ese_r; // Event status enable
    logic [7:0] sre_r; // Service request enable
    logic [7:0] stb_r; // Status byte
    logic qena_r; // Queue enable
    logic qfull_r; // Queue holds entries
    logic [15:0] rdata_r; // Answer register
    logic rvalid_r; // Answer strobe

    // Decode the named set to a one-hot select
    function automatic logic [SSR_NSETS-1:0] set_dec(input logic [3:0] s);
        logic [SSR_NSETS-1:0] d;
        d = '0;
        if (s < 4'(SSR_NSETS)) begin
            d[s] = 1'b1;
        end
        return d;
    endfunction

    // Pick one register of a set for a query
    function automatic logic [15:0] reg_pick(input ssr_reg_t r,
        input logic [15:0] c, input logic [15:0] e, input logic [15:0] n,
        input logic [15:0] f, input logic [15:0] p);
        logic [15:0] v;
        v = 16'h0000;
        unique case (r)
            SSR_REG_COND: v = c;
            SSR_REG_EVENT: v = e;
            SSR_REG_ENABLE: v = n;
            SSR_REG_FALL: v = f;
            SSR_REG_RISE: v = p;
            default: v = 16'h0000;
        endcase
        return v & SSR_DATA_MASK;
    endfunction

    // Only the named set sees the access strobe
    assign sel = acc_req ? set_dec(acc_set) : '0; // R15
    assign clr_all = cmd_cls;

    // Condition routing: children feed their parent
    always_comb begin
        for (int i = 0; i < SSR_NSETS; i++) begin
            cond_in[i] = 16'h0000;
        end
        cond_in[SSR_SET_DEV] = dev_cond;
        cond_in[SSR_SET_OPER] = oper_cond;
        // Summary bits of the children override the raw inputs
        cond_in[SSR_SET_OPER][SSR_OPER_CAL_BIT] =
            sum[SSR_SET_OPER_CAL]; // R17
        cond_in[SSR_SET_OPER][SSR_OPER_MEAS_BIT] = sum[SSR_SET_OPER_MEAS];
        cond_in[SSR_SET_OPER][SSR_OPER_TRIG_BIT] = sum[SSR_SET_OPER_TRIG];
        cond_in[SSR_SET_OPER][SSR_OPER_SENSE_BIT] =
            sum[SSR_SET_OPER_SENSE];
        cond_in[SSR_SET_OPER][SSR_OPER_LLF_BIT] = sum[SSR_SET_OPER_LLF];
        cond_in[SSR_SET_OPER][SSR_OPER_ULF_BIT] = sum[SSR_SET_OPER_ULF];
        cond_in[SSR_SET_OPER_CAL][SSR_CHILD_BIT] = oper_sub_cond[0];
        cond_in[SSR_SET_OPER_LLF][SSR_CHILD_BIT] = oper_sub_cond[1];
        cond_in[SSR_SET_OPER_MEAS][SSR_CHILD_BIT] = oper_sub_cond[2];
        cond_in[SSR_SET_OPER_SENSE][SSR_CHILD_BIT] = oper_sub_cond[3];
        cond_in[SSR_SET_OPER_TRIG][SSR_CHILD_BIT] = oper_sub_cond[4];
        cond_in[SSR_SET_OPER_ULF][SSR_CHILD_BIT] = oper_sub_cond[5];
        // Questionable branch follows the same pattern
        cond_in[SSR_SET_QUES] = ques_cond;
        cond_in[SSR_SET_QUES][SSR_QUES_CAL_BIT] = sum[SSR_SET_QUES_CAL];
        cond_in[SSR_SET_QUES][SSR_QUES_POW_BIT] = sum[SSR_SET_QUES_POW];
        cond_in[SSR_SET_QUES_CAL][SSR_CHILD_BIT] = ques_sub_cond[0];
        cond_in[SSR_SET_QUES_POW][SSR_CHILD_BIT] = ques_sub_cond[1];
    end

    // Eleven sets; the operation and questionable sets preset their mask to zeros
    for (genvar g = 0; g < SSR_NSETS; g++) begin : g_set
        localparam logic [15:0] EP =
            (g == SSR_SET_OPER || g == SSR_SET_QUES) ?
            SSR_ENA_PRESET_TOP : SSR_ENA_PRESET_OTHER;
        ssr_set #(.ENA_PRESET(EP)) u_set ( // R14
            .mclk(mclk),
            .rst(rst),
            .cond_in(cond_in[g]),
            .wr_en(sel[g] && acc_wr),
            .wr_sel(acc_reg),
            .wr_data(acc_wdata),
            .evt_rd(sel[g] && !acc_wr && acc_reg == SSR_REG_EVENT),
            .clr_evt(clr_all), // R11
            .preset(cmd_preset), // R09
            .cond_q(cond_q[g]),
            .evt_q(evt_q[g]),
            .ena_q(ena_q[g]),
            .fall_q(fall_q[g]),
            .rise_q(rise_q[g]),
            .summary(sum[g])
        );
    end

    // Query answer, registered; reads are 15-bit values
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
        end else begin
            // Strobe only for a query to a set that exists
            rvalid_r <= acc_req && !acc_wr && (|sel);
            if (acc_req && !acc_wr && (|sel)) begin
                rdata_r <= reg_pick(acc_reg, cond_q[acc_set],
                    evt_q[acc_set], ena_q[acc_set], fall_q[acc_set],
                    rise_q[acc_set]); // R04 R06 R08
            end
        end
    end

    // Queue enable: preset only; device reset has no effect
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            qena_r <= SSR_QENA_PRESET;
        end else if (cmd_preset) begin
            qena_r <= SSR_QENA_PRESET; // R10
        end
    end

    // Queue occupancy: a push in the clearing cycle survives
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            qfull_r <= 1'b0;
        end else if (queue_push && qena_r) begin
            qfull_r <= 1'b1;
        end else if (clr_all) begin
            qfull_r <= 1'b0; // R11
        end
    end

    // Enable bytes: only power-on clears them
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ese_r <= 8'h00; // R12
            sre_r <= 8'h00;
        end else begin
            if (ese_wr) begin
                ese_r <= ieee_wdata;
            end
            if (sre_wr) begin
                sre_r <= ieee_wdata;
            end
        end
    end

    // Event and status bytes: clear-status clears, new sets win
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            esr_r <= 8'h00;
            stb_r <= 8'h00;
        end else if (clr_all) begin
            esr_r <= esr_set; // R13
            stb_r <= 8'h00;
        end else begin
            esr_r <= esr_r | esr_set;
            stb_r <= {1'b0, 1'b0, |(esr_r & ese_r), 1'b0, ques_sum,
                      qfull_r, 1'b0, dev_sum} & ~8'h40;
        end
    end

    // Outputs straight from the registers and set summaries
    assign acc_rdata = rdata_r;
    assign acc_rvalid = rvalid_r;
    assign ese_q = ese_r;
    assign sre_q = sre_r;
    assign esr_q = esr_r;
    assign stb_q = stb_r;
    assign queue_ena_q = qena_r;
    assign queue_nempty_q = qfull_r;
    assign dev_sum = sum[SSR_SET_DEV];
    assign oper_sum = sum[SSR_SET_OPER];
    assign ques_sum = sum[SSR_SET_QUES];

    // Query answers carry the addressed register, bit 15 low
    AST_COND_RD: assert property (@(posedge mclk) disable iff (rst) // R01
        acc_req && !acc_wr && acc_reg == SSR_REG_COND && acc_set == 4'h0
        |=> acc_rvalid && acc_rdata == $past(cond_q[0]))
        else $error("condition answer wrong");
    AST_EVT_RD: assert property (@(posedge mclk) disable iff (rst) // R02
        acc_req && !acc_wr && acc_reg == SSR_REG_EVENT && acc_set == 4'h1
        |=> acc_rdata == $past(evt_q[1] & SSR_DATA_MASK))
        else $error("event answer wrong");
    AST_RD_TOP: assert property (@(posedge mclk) disable iff (rst) // R04
        acc_rvalid |-> !acc_rdata[15])
        else $error("answer bit 15 set");
    AST_RISE_RD: assert property (@(posedge mclk) disable iff (rst) // R08
        acc_req && !acc_wr && acc_reg == SSR_REG_RISE && acc_set == 4'h4
        |=> acc_rdata == $past(rise_q[4]))
        else $error("rising filter answer wrong");
    AST_FALL_RD: assert property (@(posedge mclk) disable iff (rst) // R06
        acc_req && !acc_wr && acc_reg == SSR_REG_FALL && acc_set == 4'h6
        |=> acc_rdata == $past(fall_q[6]))
        else $error("falling filter answer wrong");
    AST_REFUSED: assert property (@(posedge mclk) disable iff (rst) // R15
        acc_req && acc_set > 4'hA |=> !acc_rvalid)
        else $error("answer for a set that does not exist");

    // Writes land with bit 15 forced low
    AST_ENA_WR: assert property (@(posedge mclk) disable iff (rst) // R03
        acc_req && acc_wr && acc_reg == SSR_REG_ENABLE && acc_set == 4'h2
        && !cmd_preset |=> ena_q[2] == ($past(acc_wdata) & 16'h7FFF))
        else $error("enable write wrong");
    AST_FALL_WR: assert property (@(posedge mclk) disable iff (rst) // R05
        acc_req && acc_wr && acc_reg == SSR_REG_FALL && acc_set == 4'h3
        && !cmd_preset |=> fall_q[3] == ($past(acc_wdata) & 16'h7FFF))
        else $error("falling filter write wrong");

    // Command effects on masks, events, queue and standard bytes
    AST_PRESET: assert property (@(posedge mclk) disable iff (rst) // R09
        cmd_preset |=> rise_q[1] == 16'h7FFF && ena_q[1] == 16'h0000
        && fall_q[5] == 16'h0000 && ena_q[5] == 16'h7FFF && qena_r)
        else $error("preset values wrong");
    AST_CLS_ESR: assert property (@(posedge mclk) disable iff (rst) // R13
        cmd_cls && esr_set == 8'h00 |=> esr_q == 8'h00 && stb_q == 8'h00)
        else $error("clear-status left status bytes");
    AST_ESE_KEEP: assert property (@(posedge mclk) disable iff (rst) // R12
        (cmd_cls || cmd_preset || cmd_rst) && !ese_wr
        |=> ese_q == $past(ese_q))
        else $error("enable byte changed by command");
    AST_SRE_KEEP: assert property (@(posedge mclk) disable iff (rst) // R12
        (cmd_cls || cmd_preset || cmd_rst) && !sre_wr
        |=> sre_q == $past(sre_q))
        else $error("request enable changed by command");
    AST_QUEUE_CLS: assert property (@(posedge mclk) disable iff (rst) // R11
        cmd_cls && !queue_push |=> !queue_nempty_q)
        else $error("queue not emptied by clear-status");
    AST_EVT_PRESET: assert property (@(posedge mclk) disable iff (rst) // R11
        cmd_preset && !cmd_cls && !acc_req
        |=> (evt_q[0] & $past(evt_q[0])) == $past(evt_q[0]))
        else $error("status preset lost an event");
    AST_ESR_HOLD: assert property (@(posedge mclk) disable iff (rst) // R13
        cmd_preset && !cmd_cls |=> esr_q == ($past(esr_q) | $past(esr_set)))
        else $error("status preset changed event status");
    AST_RST_NOP: assert property (@(posedge mclk) disable iff (rst) // R09
        cmd_rst && !cmd_preset && !acc_req |=> ena_q[0] == $past(ena_q[0])
        && fall_q[0] == $past(fall_q[0]) && rise_q[0] == $past(rise_q[0]))
        else $error("device reset changed a mask or filter");

endmodule // ssr_top

// [ssr_top_test.sv]
// Self-checking testbench for the status register sets block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    errors++; $display("ERROR %s exp %h got %h", nm, ex, got); end end

module ssr_top_test
    import ssr_pkg::*;
();
    logic mclk; // System clock
    logic rst; // Power-on reset
    logic cmd_rst, cmd_cls, cmd_preset; // Command pulses
    logic acc_req, acc_wr; // Access strobe and direction
    logic [3:0] acc_set; // Target set
    ssr_reg_t acc_reg; // Target register
    logic [15:0] acc_wdata, acc_rdata; // Access data
    logic acc_rvalid; // Answer strobe
    logic [15:0] dev_cond, oper_cond, ques_cond; // Live conditions
    logic [5:0] oper_sub_cond; // Operation children bit 1
    logic [1:0] ques_sub_cond; // Questionable children bit 1
    logic queue_push; // Queue entry pulse
    logic [7:0] esr_set, ieee_wdata; // Standard event and data
    logic ese_wr, sre_wr; // Enable byte writes
    logic [7:0] ese_q, sre_q, esr_q, stb_q; // Standard bytes
    logic queue_ena_q, queue_nempty_q; // Queue state
    logic dev_sum, oper_sum, ques_sum; // Summaries
    int errors; // Mismatch count
    int n_compared; // Comparison count
    logic [15:0] rd; // Last answer
    logic vld; // Last answer strobe

    // Device under test
    ssr_top i_dut (.mclk, .rst, .cmd_rst, .cmd_cls, .cmd_preset, .acc_req,
        .acc_wr, .acc_set, .acc_reg, .acc_wdata, .acc_rdata, .acc_rvalid,
        .dev_cond, .oper_cond, .oper_sub_cond, .ques_cond, .ques_sub_cond,
        .queue_push, .esr_set, .ese_wr, .sre_wr, .ieee_wdata, .ese_q,
        .sre_q, .esr_q, .stb_q, .queue_ena_q, .queue_nempty_q, .dev_sum,
        .oper_sum, .ques_sum);

    // Clock at 250 MHz
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // One access: held until the taking edge, answer sampled after it
    task automatic acc(input logic wr, input logic [3:0] s,
            input ssr_reg_t r, input logic [15:0] d);
        @(posedge mclk);
        acc_req <= 1'b1;
        acc_wr <= wr;
        acc_set <= s;
        acc_reg <= r;
        acc_wdata <= d;
        @(posedge mclk);
        acc_req <= 1'b0;
        #1;
        vld = acc_rvalid;
        rd = acc_rdata;
    endtask

    // Query and compare the answer
    task automatic rd_chk(input logic [3:0] s, input ssr_reg_t r,
            input logic [15:0] ex);
        acc(1'b0, s, r, 16'h0000);
        `CHK("rvalid", 1'b1, vld)
        `CHK("rdata", ex, rd)
    endtask

    // Let some edges pass, then step off the edge
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Pulse commands: bit 0 reset, bit 1 clear-status, bit 2 preset
    task automatic cmd(input logic [2:0] k);
        @(posedge mclk);
        cmd_rst <= k[0];
        cmd_cls <= k[1];
        cmd_preset <= k[2];
        @(posedge mclk);
        {cmd_preset, cmd_cls, cmd_rst} <= 3'h0;
        wt(3);
    endtask

    // Filters and masks of every set hold their preset values
    task automatic chk_preset();
        for (int s = 0; s < 11; s++) begin
            rd_chk(4'(s), SSR_REG_ENABLE, (s == 1 || s == 8) ?
                16'h0000 : 16'h7FFF);
            rd_chk(4'(s), SSR_REG_RISE, 16'h7FFF);
            rd_chk(4'(s), SSR_REG_FALL, 16'h0000);
        end
    endtask

    // Device mask, events, queue and standard bytes
    task automatic chk_state(input logic [15:0] ena, input logic ev,
            input logic [7:0] esr, input logic [7:0] ese,
            input logic [7:0] sre);
        rd_chk(4'h0, SSR_REG_ENABLE, ena);
        `CHK("dev_sum", ev, dev_sum)
        `CHK("queue", ev, queue_nempty_q)
        `CHK("esr", esr, esr_q)
        `CHK("ese", ese, ese_q)
        `CHK("sre", sre, sre_q)
        `CHK("queue_ena", 1'b1, queue_ena_q)
    endtask

    // Counts and verdict
    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Cuts a hang short
    initial begin
        #40000;
        errors++;
        end_of_test();
    end

    // Test sequence
    initial begin
        {rst, cmd_rst, cmd_cls, cmd_preset, acc_req, acc_wr} = 6'h20;
        acc_set = 4'h0;
        acc_reg = SSR_REG_COND;
        acc_wdata = 16'h0000;
        {dev_cond, oper_cond, ques_cond} = 48'h0;
        oper_sub_cond = 6'h00;
        ques_sub_cond = 2'h0;
        {queue_push, ese_wr, sre_wr} = 3'h0;
        esr_set = 8'h00;
        ieee_wdata = 8'h00;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        // Values after power-on
        chk_preset();
        for (int s = 0; s < 11; s++) begin
            rd_chk(4'(s), SSR_REG_EVENT, 16'h0000);
            rd_chk(4'(s), SSR_REG_COND, 16'h0000);
        end
        chk_state(16'h7FFF, 1'b0, 8'h00, 8'h00, 8'h00);
        $display("Test power-on values done");
        // Writes with bit 15 set, each set and register its own value
        for (int s = 0; s < 11; s++) begin
            for (int r = 2; r < 5; r++) begin
                acc(1'b1, 4'(s), ssr_reg_t'(r),
                    {1'b1, 4'(s), 3'(r), 8'hA5});
            end
        end
        for (int s = 0; s < 11; s++) begin
            for (int r = 2; r < 5; r++) begin
                rd_chk(4'(s), ssr_reg_t'(r),
                    {1'b0, 4'(s), 3'(r), 8'hA5});
            end
        end
        // Write to condition ignored, unknown set gets no answer
        acc(1'b1, 4'h0, SSR_REG_COND, 16'hFFFF);
        rd_chk(4'h0, SSR_REG_COND, 16'h0000);
        acc(1'b0, 4'hB, SSR_REG_ENABLE, 16'h0000);
        `CHK("refused", 1'b0, vld)
        cmd(3'b100);
        chk_preset();
        $display("Test writes and preset done");
        // Rising edge latches, query clears, condition stays
        @(posedge mclk) dev_cond <= 16'h8008;
        wt(4);
        rd_chk(4'h0, SSR_REG_COND, 16'h0008);
        rd_chk(4'h0, SSR_REG_COND, 16'h0008);
        rd_chk(4'h0, SSR_REG_EVENT, 16'h0008);
        rd_chk(4'h0, SSR_REG_EVENT, 16'h0000);
        // Falling edge latches only through the falling filter
        acc(1'b1, 4'h0, SSR_REG_FALL, 16'h0008);
        acc(1'b1, 4'h0, SSR_REG_RISE, 16'h0000);
        @(posedge mclk) dev_cond <= 16'h0000;
        wt(4);
        rd_chk(4'h0, SSR_REG_EVENT, 16'h0008);
        @(posedge mclk) dev_cond <= 16'h0008;
        wt(4);
        rd_chk(4'h0, SSR_REG_EVENT, 16'h0000);
        $display("Test events done");
        // Child summary reaches the parent condition
        @(posedge mclk) oper_sub_cond <= 6'h01;
        wt(6);
        rd_chk(SSR_SET_OPER_CAL, SSR_REG_COND, 16'h0002);
        rd_chk(SSR_SET_OPER, SSR_REG_COND, 16'h0001);
        `CHK("oper_sum", 1'b0, oper_sum)
        acc(1'b1, SSR_SET_OPER, SSR_REG_ENABLE, 16'h0001);
        wt(1);
        `CHK("oper_sum", 1'b1, oper_sum)
        @(posedge mclk) ques_sub_cond <= 2'h2;
        wt(6);
        rd_chk(SSR_SET_QUES, SSR_REG_COND, 16'h0008);
        `CHK("ques_sum", 1'b0, ques_sum)
        acc(1'b1, SSR_SET_QUES, SSR_REG_ENABLE, 16'h0008);
        wt(1);
        `CHK("ques_sum", 1'b1, ques_sum)
        $display("Test summaries done");
        // Commands against events, queue and standard bytes
        acc(1'b1, 4'h0, SSR_REG_ENABLE, 16'h0F0F);
        @(posedge mclk) dev_cond <= 16'h0000;
        @(posedge mclk);
        queue_push <= 1'b1;
        esr_set <= 8'h01;
        ese_wr <= 1'b1;
        ieee_wdata <= 8'h5A;
        @(posedge mclk);
        {queue_push, ese_wr, sre_wr} <= 3'b001;
        esr_set <= 8'h00;
        ieee_wdata <= 8'hA5;
        @(posedge mclk);
        sre_wr <= 1'b0;
        wt(3);
        cmd(3'b001);
        chk_state(16'h0F0F, 1'b1, 8'h01, 8'h5A, 8'hA5);
        cmd(3'b100);
        chk_state(16'h7FFF, 1'b1, 8'h01, 8'h5A, 8'hA5);
        acc(1'b1, 4'h0, SSR_REG_ENABLE, 16'h0F0F);
        cmd(3'b010);
        chk_state(16'h0F0F, 1'b0, 8'h00, 8'h5A, 8'hA5);
        `CHK("oper_sum", 1'b0, oper_sum)
        `CHK("stb", 8'h00, stb_q)
        @(posedge mclk);
        rst <= 1'b1;
        wt(2);
        @(posedge mclk) rst <= 1'b0;
        chk_state(16'h7FFF, 1'b0, 8'h00, 8'h00, 8'h00);
        $display("Test commands done");
        end_of_test();
    end
endmodule // ssr_top_test
